// ==== hw/ssp_pkg.sv ====
// constants and carrier types for the spi slave port
package ssp_pkg;

	// register byte offsets on the 8-bit register port
	localparam logic [7:0] SSP_ADDR_STATUS  = 8'h94;
	localparam logic [7:0] SSP_ADDR_CONTROL = 8'h14;
	localparam logic [7:0] SSP_ADDR_BUFFER  = 8'h13;
	localparam logic [7:0] SSP_ADDR_PINCFG  = 8'h95;
	localparam logic [7:0] SSP_ADDR_IRQSTAT = 8'h0C;
	localparam logic [7:0] SSP_ADDR_IRQMASK = 8'h8C;

	// serial_port_status fields
	localparam int SSP_STAT_SMP = 7;
	localparam int SSP_STAT_CKE = 6;
	localparam int SSP_STAT_BF  = 0;

	// port_control fields
	localparam int SSP_CTL_EN    = 5;
	localparam int SSP_CTL_CKP   = 4;
	localparam int SSP_CTL_MODE  = 0;
	localparam int SSP_MODE_W    = 4;

	// port mode encodings
	localparam logic [3:0] SSP_MODE_SLV_SS   = 4'h4;
	localparam logic [3:0] SSP_MODE_SLV_NOSS = 4'h5;

	// pin configuration and interrupt fields
	localparam int SSP_PIN_SDO_IN = 0;
	localparam int SSP_IRQ_BYTE   = 0;
	localparam int SSP_IRQ_WAKE   = 1;
	localparam int SSP_IRQ_W      = 2;

	// values after reset, and the last bit count
	localparam logic [7:0] SSP_STATUS_RST  = 8'h00;
	localparam logic [7:0] SSP_CONTROL_RST = 8'h00;
	localparam logic [7:0] SSP_PINCFG_RST  = 8'h01;
	localparam logic [7:0] SSP_BUFFER_RST  = 8'h00;
	localparam logic [1:0] SSP_IRQ_RST     = 2'h0;
	localparam logic [2:0] SSP_BITCNT_RST  = 3'h0;
	localparam logic [2:0] SSP_BITCNT_LAST = 3'h7;

	// synchroniser depth on pins
	localparam int SSP_SYNC_STAGES = 2;

	// pins coming from the external master
	typedef struct packed {
		logic sck;
		logic sdi;
		logic ss_n;
	} ssp_pins_in_t;

	// serial data output pin, three-state
	typedef struct packed {
		logic sdo;
		logic sdo_oe;
	} ssp_pins_out_t;

endpackage

// ==== hw/ssp_sync.sv ====
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module ssp_sync
	import ssp_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// first stage is read by the second stage only
	logic [WIDTH-1:0] meta;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// ==== hw/ssp_spi_slave.sv ====
// spi slave shift logic, status/control registers and interrupt
`timescale 1ns/100ps
//Contract
// [R1] master samples at end of output time if phase bit set, else middle
// [R2] edge bit 1 shifts out on active-to-idle, 0 on idle-to-active
// [R3] buffer-full reads 1 after a complete byte, 0 when empty
// [R4] slave shifts only on master clock pulses, makes no clock
// [R5] slave sets port interrupt flag when final bit is latched
// [R6] keeps shifting in sleep and wakes core on a received byte
// [R7] select pin gates only in the slave-with-select mode encoding
// [R8] software keeps select pin an input with its latch high
// [R9] select low enables shifting both ways and drives sdo
// [R10] select high floats sdo at once, even mid byte
// [R11] select high or port disable forces bit counter to zero
// [R12] software picks select-gated mode when edge bit set in slave
// [R13] sdo configured as input never transmits
// [R14] completed byte copied to receive buffer, interrupt flag set
// [R15] write to data buffer loads buffer and shift register; a byte completing that cycle takes the buffer
// [R16] i2c-only status bits read as zero in spi operation
module ssp_spi_slave
	import ssp_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          arst_n,
	input  wire logic [7:0]    reg_addr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic      [7:0]    reg_rdata,
	input  wire ssp_pins_in_t  pins_in,
	output ssp_pins_out_t      pins_out,
	input  wire logic          sleep_mode,
	output logic               wake,
	output logic               irq
);

	// true for both slave encodings; master modes are not built here
	function automatic logic is_slave(input logic [SSP_MODE_W-1:0] m);
		is_slave = (m == SSP_MODE_SLV_SS) || (m == SSP_MODE_SLV_NOSS);
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	ssp_pins_in_t       pins_s;
	logic               sck_d;
	logic [7:0]         status;
	logic [7:0]         control;
	logic [7:0]         pincfg;
	logic [7:0]         rx_tx_buffer;
	logic [7:0]         serial_shift_register;
	logic [2:0]         bitcnt;
	logic               sdo_q;
	logic [SSP_IRQ_W-1:0] irq_stat;
	logic [SSP_IRQ_W-1:0] irq_mask;

	logic               port_en;
	logic               clock_idle_polarity;
	logic               cke;
	logic [SSP_MODE_W-1:0] mode;
	logic               slave_on;
	logic               ss_mode;
	logic               port_rst;
	logic               shift_en;
	logic               sdo_in_cfg;
	logic               sck_rise;
	logic               sck_fall;
	logic               edge_to_active;
	logic               edge_to_idle;
	logic               smp_edge;
	logic               out_edge;
	logic               byte_done;
	logic               buf_wr;
	logic               buf_rd;
	logic [7:0]         rx_byte;
	logic [SSP_IRQ_W-1:0] irq_set;
	logic [SSP_IRQ_W-1:0] irq_clr;

	// pins from the master are asynchronous to mclk
	ssp_sync #(
		.WIDTH($bits(ssp_pins_in_t))
	) u_sync (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.async_in(pins_in),
		.sync_out(pins_s)
	);

	assign port_en    = control[SSP_CTL_EN];
	assign clock_idle_polarity        = control[SSP_CTL_CKP];
	assign mode       = control[SSP_CTL_MODE +: SSP_MODE_W];
	assign cke        = status[SSP_STAT_CKE];
	assign sdo_in_cfg = pincfg[SSP_PIN_SDO_IN];
	assign slave_on   = port_en && is_slave(mode);
	assign ss_mode    = (mode == SSP_MODE_SLV_SS); // R7

	// port reset: disable, or select released in select-gated mode
	assign port_rst = !port_en || (slave_on && ss_mode && pins_s.ss_n); // R11

	// other encodings ignore the select pin entirely
	assign shift_en = slave_on && (!ss_mode || !pins_s.ss_n); // R7 R9

	// edges of the master's clock, found on the synchronised copy
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sck_d <= 1'b0;
		end else begin
			sck_d <= pins_s.sck;
		end
	end

	assign sck_rise = pins_s.sck && !sck_d; // R4
	assign sck_fall = !pins_s.sck && sck_d; // R4

	// idle level is the polarity bit; leaving it is the active edge
	assign edge_to_active = clock_idle_polarity ? sck_fall : sck_rise;
	assign edge_to_idle   = clock_idle_polarity ? sck_rise : sck_fall;

	// output edge by the edge-select bit
	assign out_edge = cke ? edge_to_idle : edge_to_active; // R2
	// slave samples at mid-bit, the edge opposite the output edge;
	// end-of-bit sampling only applies to master clocking
	assign smp_edge = cke ? edge_to_active : edge_to_idle; // R1

	assign byte_done = shift_en && smp_edge && (bitcnt == SSP_BITCNT_LAST);
	assign rx_byte   = {serial_shift_register[6:0], pins_s.sdi};

	assign buf_wr = reg_wr && hit(reg_addr, SSP_ADDR_BUFFER);
	assign buf_rd = reg_rd && hit(reg_addr, SSP_ADDR_BUFFER);

	// bit counter
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			bitcnt <= SSP_BITCNT_RST;
		end else if (port_rst) begin
			bitcnt <= SSP_BITCNT_RST; // R11
		end else if (shift_en && smp_edge) begin
			bitcnt <= bitcnt + 3'h1; // R4
		end
	end

	// shift register: software load beats a coincident sample edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			serial_shift_register <= SSP_BUFFER_RST;
		end else if (buf_wr) begin
			serial_shift_register <= reg_wdata; // R15
		end else if (shift_en && smp_edge) begin
			serial_shift_register <= rx_byte; // R4 R9
		end
	end

	// receive buffer; a write loads it too since tx is single-buffered; a new byte wins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_tx_buffer <= SSP_BUFFER_RST;
		end else if (byte_done) begin
			rx_tx_buffer <= rx_byte; // R14
		end else if (buf_wr) begin
			rx_tx_buffer <= reg_wdata; // R15
		end
	end

	// data bit on sdo: msb ready at load, next bit on each output edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sdo_q <= 1'b0;
		end else if (buf_wr) begin
			sdo_q <= reg_wdata[7]; // R15
		end else if (shift_en && out_edge) begin
			sdo_q <= serial_shift_register[7]; // R2 R9
		end
	end

	// drive enable follows the select pin in select-gated mode, not the byte position
	assign pins_out.sdo    = sdo_q;
	assign pins_out.sdo_oe = shift_en && !sdo_in_cfg; // R9 R10 R13

	// status: only the phase and edge bits are writable
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			status <= SSP_STATUS_RST;
		end else begin
			if (reg_wr && hit(reg_addr, SSP_ADDR_STATUS)) begin
				status[SSP_STAT_SMP] <= reg_wdata[SSP_STAT_SMP]; // R1
				status[SSP_STAT_CKE] <= reg_wdata[SSP_STAT_CKE]; // R2
			end
			// reading the buffer empties it; a new byte wins
			if (byte_done) begin
				status[SSP_STAT_BF] <= 1'b1; // R3
			end else if (buf_rd || !port_en) begin
				status[SSP_STAT_BF] <= 1'b0; // R3
			end
			status[5:1] <= 5'h00; // R16
		end
	end

	// control and pin direction
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			control <= SSP_CONTROL_RST;
			pincfg  <= SSP_PINCFG_RST;
		end else begin
			if (reg_wr && hit(reg_addr, SSP_ADDR_CONTROL)) begin
				control <= reg_wdata;
			end
			if (reg_wr && hit(reg_addr, SSP_ADDR_PINCFG)) begin
				pincfg <= reg_wdata;
			end
		end
	end

	// interrupt status: set wins over write-one-to-clear
	assign irq_set[SSP_IRQ_BYTE] = byte_done; // R5 R14
	assign irq_set[SSP_IRQ_WAKE] = byte_done && sleep_mode; // R6
	assign irq_clr = (reg_wr && hit(reg_addr, SSP_ADDR_IRQSTAT)) ?
		reg_wdata[SSP_IRQ_W-1:0] : SSP_IRQ_RST;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat <= SSP_IRQ_RST;
		end else begin
			irq_stat <= irq_set | (irq_stat & ~irq_clr);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask <= SSP_IRQ_RST;
		end else if (reg_wr && hit(reg_addr, SSP_ADDR_IRQMASK)) begin
			irq_mask <= reg_wdata[SSP_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat & irq_mask);

	// wake stands until software clears the wake status bit
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake <= 1'b0;
		end else if (irq_set[SSP_IRQ_WAKE]) begin
			wake <= 1'b1; // R6
		end else if (irq_clr[SSP_IRQ_WAKE]) begin
			wake <= 1'b0;
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata <= 8'h00;
		end else if (hit(reg_addr, SSP_ADDR_STATUS)) begin
			reg_rdata <= status; // R3 R16
		end else if (hit(reg_addr, SSP_ADDR_CONTROL)) begin
			reg_rdata <= control;
		end else if (hit(reg_addr, SSP_ADDR_BUFFER)) begin
			reg_rdata <= rx_tx_buffer;
		end else if (hit(reg_addr, SSP_ADDR_PINCFG)) begin
			reg_rdata <= pincfg;
		end else if (hit(reg_addr, SSP_ADDR_IRQSTAT)) begin
			reg_rdata <= {6'h00, irq_stat};
		end else if (hit(reg_addr, SSP_ADDR_IRQMASK)) begin
			reg_rdata <= {6'h00, irq_mask};
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	a_bf_on_byte: assert property (@(posedge mclk) disable iff (!arst_n) // R3
		byte_done |=> status[SSP_STAT_BF] && rx_tx_buffer == $past(rx_byte))
		else $error("buffer full not set after byte");

	a_irq_on_byte: assert property (@(posedge mclk) disable iff (!arst_n) // R5
		byte_done |=> irq_stat[SSP_IRQ_BYTE])
		else $error("irq flag not set on last bit");

	a_wake_in_sleep: assert property (@(posedge mclk) disable iff (!arst_n) // R6
		byte_done && sleep_mode |=> wake && irq_stat[SSP_IRQ_WAKE])
		else $error("no wake on byte in sleep");

	a_sdo_float_ss: assert property (@(posedge mclk) disable iff (!arst_n) // R10
		ss_mode && pins_s.ss_n |-> !pins_out.sdo_oe)
		else $error("sdo driven with select high");

	a_sdo_drive_ss: assert property (@(posedge mclk) disable iff (!arst_n) // R9
		slave_on && !pins_s.ss_n && !sdo_in_cfg |-> pins_out.sdo_oe)
		else $error("sdo not driven with select low");

	a_cnt_port_rst: assert property (@(posedge mclk) disable iff (!arst_n) // R11
		port_rst |=> bitcnt == SSP_BITCNT_RST)
		else $error("bit counter not cleared by port reset");

	a_no_clk_hold: assert property (@(posedge mclk) disable iff (!arst_n) // R4
		!(shift_en && smp_edge) && !buf_wr |=>
			$stable(serial_shift_register) && $stable(bitcnt) || $past(port_rst))
		else $error("shift without master clock edge");

	a_sdo_in_cfg: assert property (@(posedge mclk) disable iff (!arst_n) // R13
		sdo_in_cfg |-> !pins_out.sdo_oe)
		else $error("sdo driven while configured input");

	a_load_both: assert property (@(posedge mclk) disable iff (!arst_n) // R15
		buf_wr && !byte_done |=> serial_shift_register == $past(reg_wdata)
			&& rx_tx_buffer == $past(reg_wdata) && sdo_q == $past(reg_wdata[7]))
		else $error("buffer write did not load both");

	a_i2c_bits_zero: assert property (@(posedge mclk) disable iff (!arst_n) // R16
		reg_rd && hit(reg_addr, SSP_ADDR_STATUS) |=> reg_rdata[5:1] == 5'h00)
		else $error("i2c status bits not zero");

	a_out_edge_bit: assert property (@(posedge mclk) disable iff (!arst_n) // R2
		shift_en && out_edge && !buf_wr |=>
			sdo_q == $past(serial_shift_register[7]))
		else $error("sdo not updated on output edge");

	a_ss_ignored: assert property (@(posedge mclk) disable iff (!arst_n) // R7
		slave_on && !ss_mode |-> shift_en)
		else $error("select pin gated outside select mode");

	a_bf_clr_read: assert property (@(posedge mclk) disable iff (!arst_n) // R3
		buf_rd && !byte_done |=> !status[SSP_STAT_BF])
		else $error("buffer full not cleared by read");

	a_buf_rd_data: assert property (@(posedge mclk) disable iff (!arst_n) // R14
		buf_rd |=> reg_rdata == $past(rx_tx_buffer))
		else $error("buffer read returned wrong byte");

	a_cnt_byte_end: assert property (@(posedge mclk) disable iff (!arst_n) // R5
		byte_done |=> bitcnt == SSP_BITCNT_RST)
		else $error("bit counter not back at zero after byte");

	a_idle_no_shift: assert property (@(posedge mclk) disable iff (!arst_n) // R4
		!slave_on |=> $stable(serial_shift_register) || $past(buf_wr))
		else $error("shift register moved outside slave mode");

	a_oe_off_idle: assert property (@(posedge mclk) disable iff (!arst_n) // R9
		!slave_on |-> !pins_out.sdo_oe)
		else $error("sdo driven outside slave mode");

	a_wake_awake: assert property (@(posedge mclk) disable iff (!arst_n) // R6
		byte_done && !sleep_mode && !wake |=> !wake)
		else $error("wake raised while awake");

endmodule

// ==== sim/ssp_master_model.sv ====
// behavioural spi master that clocks the slave port from outside
`timescale 1ns/100ps
module ssp_master_model
	import ssp_pkg::*;
(
	output ssp_pins_in_t       pins,
	input  wire ssp_pins_out_t pout
);
	initial pins = '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};
	// idle level is set only while the port is disabled
	task automatic park(input logic clock_idle_polarity);
		pins.sck = clock_idle_polarity;
	endtask
	task automatic sel(input logic lvl);
		#7 pins.ss_n = lvl;
		#200;
	endtask
	// n bits msb first; sdi is inverted afterwards since nobody drives it
	task automatic xfer(input logic [7:0] tx, input int n,
		input logic cke, input logic clock_idle_polarity, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			if (cke)
				pins.sdi = tx[i];
			#80 pins.sck = ~clock_idle_polarity;
			if (!cke)
				pins.sdi = tx[i];
			// a floating sdo reads as the inverse of its last level
			#79 rx[i] = pout.sdo_oe ? pout.sdo : !pout.sdo;
			#1 pins.sck = clock_idle_polarity;
		end
		#80 pins.sdi = ~pins.sdi;
	endtask
endmodule

// ==== sim/spi_slave_status_and_select_test.sv ====
// self-checking bench for the spi slave port
`timescale 1ns/100ps
module spi_slave_status_and_select_test
	import ssp_pkg::*;
;
	typedef struct packed {
		logic       cke;
		logic       clock_idle_polarity;
		logic [3:0] mode;
		logic       ss_n;
		logic [7:0] tx;
		logic [7:0] mtx;
	} ssp_row_t;
	logic          mclk;
	logic          arst_n;
	logic [7:0]    reg_addr;
	logic [7:0]    reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [7:0]    reg_rdata;
	ssp_pins_in_t  pins_in;
	ssp_pins_out_t pins_out;
	logic          sleep_mode;
	logic          wake;
	logic          irq;
	logic [7:0]    rx;
	int            err_count;
	int            num_checks;
	ssp_row_t      rows [4];
	ssp_row_t      r;

	ssp_spi_slave i_ssp_spi_slave (.mclk(mclk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
		.pins_out(pins_out), .sleep_mode(sleep_mode), .wake(wake),
		.irq(irq));
	ssp_master_model i_ssp_master_model (.pins(pins_in), .pout(pins_out));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#30;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic sel(input logic l);
		i_ssp_master_model.sel(l);
	endtask
	task automatic spi(input logic [7:0] tx, input int n, input logic cke);
		i_ssp_master_model.xfer(tx, n, cke, r.clock_idle_polarity, rx);
	endtask

	initial begin
		#200000;
		err_count++;
		wrap_up();
	end

	initial begin
		arst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sleep_mode = 1'b0;
		err_count = 0;
		num_checks = 0;
		rows[0] = '{1'b1, 1'b0, SSP_MODE_SLV_SS, 1'b0, 8'hA5, 8'h3C};
		rows[1] = '{1'b1, 1'b1, SSP_MODE_SLV_SS, 1'b0, 8'h5A, 8'hC3};
		rows[2] = '{1'b0, 1'b0, SSP_MODE_SLV_SS, 1'b0, 8'h81, 8'h7E};
		rows[3] = '{1'b0, 1'b1, SSP_MODE_SLV_NOSS, 1'b1, 8'h00, 8'hFF};
		repeat (12) @(posedge mclk);
		arst_n <= 1'b1;
		rc(SSP_ADDR_STATUS, SSP_STATUS_RST);
		rc(SSP_ADDR_PINCFG, SSP_PINCFG_RST);
		rc(8'h55, 8'h00);
		chk(8'(pins_out.sdo_oe), 8'h00);
		chk(8'(irq), 8'h00);
		wr(SSP_ADDR_STATUS, 8'hFF);
		rc(SSP_ADDR_STATUS, 8'hC0);
		wr(SSP_ADDR_PINCFG, 8'h00);
		foreach (rows[k]) begin
			r = rows[k];
			wr(SSP_ADDR_CONTROL, 8'h00);
			i_ssp_master_model.park(r.clock_idle_polarity);
			wr(SSP_ADDR_STATUS, {1'b0, r.cke, 6'h00});
			wr(SSP_ADDR_CONTROL, {3'b001, r.clock_idle_polarity, r.mode});
			wr(SSP_ADDR_BUFFER, r.tx);
			sel(r.ss_n);
			if (r.mode == SSP_MODE_SLV_SS)
				chk(8'(pins_out.sdo_oe), 8'h01);
			spi(r.mtx, 8, r.cke);
			sel(1'b1);
			if (r.mode == SSP_MODE_SLV_SS)
				chk(8'(pins_out.sdo_oe), 8'h00);
			rc(SSP_ADDR_STATUS, {1'b0, r.cke, 6'h01});
			rc(SSP_ADDR_IRQSTAT, 8'h01);
			rc(SSP_ADDR_BUFFER, r.mtx);
			rc(SSP_ADDR_STATUS, {1'b0, r.cke, 6'h00});
			chk(rx, r.tx);
			wr(SSP_ADDR_IRQSTAT, 8'h01);
		end
		// a non-slave encoding ignores the master's clock
		wr(SSP_ADDR_CONTROL, {3'b001, r.clock_idle_polarity, 4'h0});
		spi(8'h5A, 8, 1'b0);
		chk(8'(pins_out.sdo_oe), 8'h00);
		// select held high in mode 4 must block shifting
		wr(SSP_ADDR_CONTROL, {3'b001, r.clock_idle_polarity, SSP_MODE_SLV_SS});
		spi(8'h77, 8, 1'b0);
		repeat (6) @(posedge mclk);
		rc(SSP_ADDR_STATUS, 8'h00);
		// partial byte cut by deselect, then a whole byte
		sel(1'b0);
		spi(8'hF0, 4, 1'b0);
		sel(1'b1);
		chk(8'(pins_out.sdo_oe), 8'h00);
		sel(1'b0);
		spi(8'h69, 8, 1'b0);
		repeat (6) @(posedge mclk);
		rc(SSP_ADDR_BUFFER, 8'h69);
		// partial byte cut by port disable
		spi(8'hFF, 3, 1'b0);
		wr(SSP_ADDR_CONTROL, 8'h00);
		wr(SSP_ADDR_CONTROL, {3'b001, r.clock_idle_polarity, SSP_MODE_SLV_SS});
		spi(8'h96, 8, 1'b0);
		sel(1'b1);
		rc(SSP_ADDR_BUFFER, 8'h96);
		wr(SSP_ADDR_PINCFG, 8'h01);
		sel(1'b0);
		chk(8'(pins_out.sdo_oe), 8'h00);
		// byte received while asleep
		@(posedge mclk);
		sleep_mode <= 1'b1;
		wr(SSP_ADDR_IRQSTAT, 8'h03);
		wr(SSP_ADDR_IRQMASK, 8'h03);
		spi(8'h3C, 8, 1'b0);
		sel(1'b1);
		chk(8'(wake), 8'h01);
		chk(8'(irq), 8'h01);
		wr(SSP_ADDR_IRQSTAT, 8'h02);
		chk(8'(wake), 8'h00);
		wr(SSP_ADDR_IRQMASK, 8'h00);
		chk(8'(irq), 8'h00);
		wr(SSP_ADDR_IRQMASK, 8'h01);
		chk(8'(irq), 8'h01);
		wr(SSP_ADDR_IRQSTAT, 8'h01);
		chk(8'(irq), 8'h00);
		wrap_up();
	end
endmodule
